// ===== host_bus_model.sv
// ====================
// Host and board straps
// ====================
module host_bus_model
    import host_port_pkg::*;
(
    // Clock
    input  wire logic  mclk,
    // Straps
    output logic [1:0] interfaceSelect,
    output logic       busTypeStrap,
    // Control pins
    output logic [6:0] addrPin,
    output logic       aleA7Pin,
    output logic       readPin,
    output logic       writePin,
    output logic       chipSelectPinN,
    output logic [1:0] txModeMidPin,
    output logic [7:0] adIn
);
    timeunit 1ns;
    timeprecision 1ps;

    // Deselected and idle from time zero
    initial
    begin
        {interfaceSelect, busTypeStrap, addrPin, aleA7Pin} = '0;
        {readPin, writePin, chipSelectPinN, txModeMidPin, adIn} = 13'h1c00;
    end

    // New personality, strobes idle, address pins low
    task automatic setMode(input logic [1:0] m, input logic b);
        @(posedge mclk);
        interfaceSelect <= m;
        busTypeStrap    <= b;
        readPin         <= !(b && m == MODE_NONMUX);
        writePin        <= 1'b1;
        chipSelectPinN  <= 1'b1;
        addrPin         <= 7'h00;
        aleA7Pin        <= 1'b0;
    endtask : setMode

    // One bus access, strobe left asserted for the caller
    task automatic access(input logic isWr, input logic [7:0] addr, input logic csLow);
        @(posedge mclk);
        if (interfaceSelect == MODE_MUX)
        begin
            adIn     <= addr;
            aleA7Pin <= 1'b1;
            @(posedge mclk);
            @(posedge mclk);
            aleA7Pin <= 1'b0;
            // Shared lines move on, so a late latch shows up
            adIn     <= ~addr;
        end
        else
            {aleA7Pin, addrPin} <= addr;
        @(posedge mclk);
        chipSelectPinN <= !csLow;
        if (!busTypeStrap)
        begin
            if (isWr)
                writePin <= 1'b0;
            else
                readPin <= 1'b0;
        end
        else
        begin
            readPin  <= (interfaceSelect == MODE_NONMUX);
            writePin <= !isWr;
        end
    endtask : access

    // Static strap levels, held until changed
    task automatic straps(input logic [21:0] v);
        @(posedge mclk);
        {busTypeStrap, addrPin, aleA7Pin, readPin, writePin, chipSelectPinN, txModeMidPin, adIn} <= v;
    endtask : straps
endmodule : host_bus_model

// ===== host_port_pin_mode_decode.sv
module host_port_pin_mode_decode
    import host_port_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       resetn,
    // Personality straps
    input  wire logic [1:0] interfaceSelect,
    input  wire logic       busTypeStrap,
    // Shared control pins
    input  wire logic [6:0] addrPin,
    input  wire logic       aleA7Pin,
    input  wire logic       readPin,
    input  wire logic       writePin,
    input  wire logic       chipSelectPinN,
    input  wire logic [1:0] txModeMidPin,
    // Shared address/data lines, input side
    input  wire logic [7:0] adIn,
    // Parallel access decode
    output logic [7:0]      regAddr,
    output logic            readReq,
    output logic            writeReq,
    // Serial port setup
    output logic            serialSelect,
    output logic            serialClkPolarity,
    output logic            serialClkPhase,
    // Hardware-mode configuration
    output logic            hwModeActive,
    output logic            e1Term75,
    output logic            zeroSubstTx,
    output logic            zeroSubstRx,
    output logic            remoteLoop,
    output logic [1:0]      clockPrescale,
    output logic [2:0]      buildOut,
    output logic [3:0]      txMode,
    output logic [3:0]      rxMode,
    output logic            txAlarmSend
);

    import host_port_pkg::*;

    // =====================================================================
    // Personality decode
    // =====================================================================
    logic       muxMode;        // Multiplexed parallel
    logic       nonMuxMode;     // Non-multiplexed parallel
    logic       serialMode;     // Serial port
    logic       hwMode;         // Hardware straps
    logic [3:0] txModeNow;      // Tx mode straps as seen now
    logic [3:0] rxModeNow;      // Rx mode straps as seen now

    // One-hot view of the select strap
    assign muxMode    = (interfaceSelect == MODE_MUX);
    assign nonMuxMode = (interfaceSelect == MODE_NONMUX);
    assign serialMode = (interfaceSelect == MODE_SERIAL);
    assign hwMode     = (interfaceSelect == MODE_HW);

    // Mode straps gathered from the pins they share
    assign txModeNow = {writePin, txModeMidPin, addrPin[5]};
    assign rxModeNow = {adIn[1], readPin, adIn[5], adIn[4]};

    // =====================================================================
    // Strobe decode
    // =====================================================================
    logic       strobeActive;   // Read or data strobe asserted
    logic       readCycle;      // Strobe set says read
    logic       writeCycle;     // Strobe set says write
    logic       selected;       // Parallel mode and chip select low
    logic [2:0] levels;         // Read, write, latch levels
    logic [2:0] rises;          // Their rising edges

    // Data strobe flips polarity only in non-multiplexed alternate timing
    assign strobeActive = (nonMuxMode && busTypeStrap) ? readPin : ~readPin;

    // Alternate timing uses a direction pin; default uses two strobes
    assign readCycle  = busTypeStrap ? (strobeActive & writePin) : strobeActive;
    assign writeCycle = busTypeStrap ? (strobeActive & ~writePin) : ~writePin;

    // Hardware and serial modes never reach the parallel access path
    assign selected = ~chipSelectPinN & (muxMode | nonMuxMode);

    assign levels = {aleA7Pin & muxMode, writeCycle & selected, readCycle & selected};

    // Edge detection for strobes and address latch
    rise_detect edges
    (
        .mclk   (mclk),
        .resetn (resetn),
        .level  (levels),
        .rise   (rises)
    );

    // =====================================================================
    // Parallel access
    // =====================================================================
    logic [7:0] regAddr_reg;   // Address of current access
    logic       readReq_reg;   // Read pulse
    logic       writeReq_reg;  // Write pulse

    // Address source depends on bus personality
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            regAddr_reg <= ADDR_RESET;
        else if (nonMuxMode)
            regAddr_reg <= {aleA7Pin, addrPin};
        else if (muxMode && rises[2])
            regAddr_reg <= adIn;
    end

    // One pulse per strobe assertion; a held strobe is one access
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            {readReq_reg, writeReq_reg} <= {BIT_RESET, BIT_RESET};
        else
            {readReq_reg, writeReq_reg} <= {rises[0], rises[1]};
    end

    assign regAddr  = regAddr_reg;
    assign readReq  = readReq_reg;
    assign writeReq = writeReq_reg;

    // =====================================================================
    // Serial port setup
    // =====================================================================
    logic serialSelect_reg;  // Serial access window
    logic cpol_reg;          // Clock polarity
    logic cpha_reg;          // Clock phase

    // Polarity and phase follow their pins only in serial mode
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            serialSelect_reg <= BIT_RESET;
            cpol_reg         <= BIT_RESET;
            cpha_reg         <= BIT_RESET;
        end
        else
        begin
            serialSelect_reg <= serialMode & ~chipSelectPinN;
            if (serialMode)
            begin
                cpol_reg <= addrPin[5];
                cpha_reg <= addrPin[4];
            end
        end
    end

    assign serialSelect      = serialSelect_reg;
    assign serialClkPolarity = cpol_reg;
    assign serialClkPhase    = cpha_reg;

    // =====================================================================
    // Hardware-mode straps
    // =====================================================================
    logic       hw_reg;          // Hardware mode flag
    logic       e1Term_reg;      // 1 = 75 ohm
    logic       zsTx_reg;        // Tx zero substitution
    logic       zsRx_reg;        // Rx zero substitution
    logic       loop_reg;        // Remote loopback
    logic [1:0] prescale_reg;    // PLL prescale
    logic [2:0] buildOut_reg;    // Line build-out
    logic [3:0] txMode_reg;      // Tx operating mode
    logic [3:0] rxMode_reg;      // Rx operating mode
    logic       alarm_reg;       // AIS send

    // Straps resampled every cycle; outside hardware mode all fall to
    // defaults so a mode change cannot leave stale configuration behind
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            hw_reg       <= BIT_RESET;
            e1Term_reg   <= BIT_RESET;
            prescale_reg <= PRESCALE_RESET;
            buildOut_reg <= BUILDOUT_RESET;
            txMode_reg   <= MODE_RESET;
            rxMode_reg   <= MODE_RESET;
        end
        else
        begin
            hw_reg       <= hwMode;
            e1Term_reg   <= hwMode ? addrPin[0] : BIT_RESET;
            prescale_reg <= hwMode ? {aleA7Pin, addrPin[6]} : PRESCALE_RESET;
            buildOut_reg <= hwMode ? addrPin[4:2] : BUILDOUT_RESET;
            txMode_reg   <= hwMode ? txModeNow : MODE_RESET;
            rxMode_reg   <= hwMode ? rxModeNow : MODE_RESET;
        end
    end

    // Mode-qualified features, judged on the modes seen this cycle
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            zsTx_reg  <= BIT_RESET;
            zsRx_reg  <= BIT_RESET;
            loop_reg  <= BIT_RESET;
            alarm_reg <= BIT_RESET;
        end
        else
        begin
            zsTx_reg  <= hwMode & busTypeStrap & isT1E1(txModeNow);
            zsRx_reg  <= hwMode & busTypeStrap & isT1E1(rxModeNow);
            // Loopback with mismatched sides is meaningless, so it is held off
            loop_reg  <= hwMode & chipSelectPinN & (txModeNow == rxModeNow);
            alarm_reg <= hwMode & addrPin[1] & isT1E1(txModeNow);
        end
    end

    assign hwModeActive  = hw_reg;
    assign e1Term75      = e1Term_reg;
    assign zeroSubstTx   = zsTx_reg;
    assign zeroSubstRx   = zsRx_reg;
    assign remoteLoop    = loop_reg;
    assign clockPrescale = prescale_reg;
    assign buildOut      = buildOut_reg;
    assign txMode        = txMode_reg;
    assign rxMode        = rxMode_reg;
    assign txAlarmSend   = alarm_reg;

    // =====================================================================
    // Assertions
    // =====================================================================
    a_read_needs_cs: assert property (@(posedge mclk) disable iff (!resetn)
        readReq |-> !$past(chipSelectPinN, 1) && !$past(serialMode | hwMode, 1))
        else $error("read pulse without chip select in parallel mode");

    a_write_needs_cs: assert property (@(posedge mclk) disable iff (!resetn)
        writeReq |-> !$past(chipSelectPinN, 1) && !$past(hwMode, 1))
        else $error("write pulse without chip select in parallel mode");

    a_read_single: assert property (@(posedge mclk) disable iff (!resetn)
        readReq |=> !readReq)
        else $error("read pulse longer than one cycle");

    a_nonmux_addr: assert property (@(posedge mclk) disable iff (!resetn)
        nonMuxMode |=> regAddr == $past({aleA7Pin, addrPin}, 1))
        else $error("non-multiplexed address not taken from address pins");

    a_mux_hold: assert property (@(posedge mclk) disable iff (!resetn)
        (muxMode && !rises[2]) |=> $stable(regAddr))
        else $error("multiplexed address changed without latch edge");

    a_mux_latch: assert property (@(posedge mclk) disable iff (!resetn)
        (muxMode && rises[2]) |=> regAddr == $past(adIn, 1))
        else $error("multiplexed address not latched from shared lines");

    a_serial_cpol: assert property (@(posedge mclk) disable iff (!resetn)
        serialMode ##1 serialMode |-> serialClkPolarity == $past(addrPin[5], 1)
            && serialClkPhase == $past(addrPin[4], 1))
        else $error("serial clock setup not following its pins");

    a_e1_term: assert property (@(posedge mclk) disable iff (!resetn)
        hwMode |=> e1Term75 == $past(addrPin[0], 1) && hwModeActive)
        else $error("termination select not following strap");

    a_loop_modes: assert property (@(posedge mclk) disable iff (!resetn)
        remoteLoop |-> $past(txModeNow, 1) == $past(rxModeNow, 1))
        else $error("remote loop with unequal tx and rx modes");

    a_alarm_mode: assert property (@(posedge mclk) disable iff (!resetn)
        txAlarmSend |-> $past(hwMode & addrPin[1] & isT1E1(txModeNow), 1))
        else $error("alarm sent outside a T1/E1 mode or without strap");

    a_hw_config: assert property (@(posedge mclk) disable iff (!resetn)
        hwMode ##1 hwMode |-> clockPrescale == $past({aleA7Pin, addrPin[6]}, 1)
            && buildOut == $past(addrPin[4:2], 1))
        else $error("prescale or build-out not following straps");

    a_hw_no_access: assert property (@(posedge mclk) disable iff (!resetn)
        hwMode [*2] |-> !readReq && !writeReq)
        else $error("bus access pulse in hardware mode");

endmodule : host_port_pin_mode_decode

// ===== host_port_pkg.sv
package host_port_pkg;

    // =====================================================================
    // Interface-select codes
    // =====================================================================
    localparam logic [1:0] MODE_MUX    = 2'h0;  // Multiplexed parallel bus
    localparam logic [1:0] MODE_NONMUX = 2'h1;  // Non-multiplexed parallel bus
    localparam logic [1:0] MODE_SERIAL = 2'h2;  // Serial port
    localparam logic [1:0] MODE_HW     = 2'h3;  // Hardware strap mode

    // =====================================================================
    // Operating-mode classification
    // =====================================================================
    // One bit per 4-bit mode code; a set bit marks a T1 or E1 mode.
    // Plain default, adjust to the mode map of the line side.
    localparam logic [15:0] T1E1_MODE_MASK = 16'h00ff;

    // =====================================================================
    // Reset values
    // =====================================================================
    localparam logic [7:0] ADDR_RESET     = 8'h00;  // Register address
    localparam logic [1:0] PRESCALE_RESET = 2'h0;   // Clock prescale
    localparam logic [2:0] BUILDOUT_RESET = 3'h0;   // Line build-out
    localparam logic [3:0] MODE_RESET     = 4'h0;   // Tx and rx modes
    localparam logic       BIT_RESET      = 1'b0;   // Single-bit flags

    // =====================================================================
    // Helpers
    // =====================================================================
    // True when a 4-bit operating mode is a T1 or E1 mode
    function automatic logic isT1E1(input logic [3:0] mode);
        return T1E1_MODE_MASK[mode];
    endfunction : isT1E1

endpackage : host_port_pkg

// ===== rise_detect.sv
// =====================================================================
// Rising-edge detector for a small group of synchronous levels
// =====================================================================
module rise_detect
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       resetn,
    // Levels in, one-cycle pulses out
    input  wire logic [2:0] level,
    output logic      [2:0] rise
);

    logic [2:0] prev_reg;  // Level seen one cycle ago

    // Remember the previous level
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            prev_reg <= 3'h0;
        else
            prev_reg <= level;
    end

    // High for one cycle where the level went from low to high
    assign rise = level & ~prev_reg;

endmodule : rise_detect

// ===== tb_top.sv
// ====================
// Pin decode bench
// ====================
module tb_top
    import host_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk, resetn, busTypeStrap, aleA7Pin, readPin, writePin, chipSelectPinN;
    logic [1:0] interfaceSelect, txModeMidPin, clockPrescale;
    logic [6:0] addrPin;
    logic [7:0] adIn, regAddr;
    logic readReq, writeReq, serialSelect, serialClkPolarity, serialClkPhase, hwModeActive;
    logic e1Term75, zeroSubstTx, zeroSubstRx, remoteLoop, txAlarmSend;
    logic [2:0] buildOut;
    logic [3:0] txMode, rxMode;
    logic [17:0] hwOut; // Hardware-mode outputs
    logic [21:0] v; // Strap vector
    logic [7:0] addr;
    logic [1:0] cp;
    int seed = 47594;
    int n_fail = 0;
    int samples_checked = 0;

    assign hwOut = {e1Term75, zeroSubstTx, zeroSubstRx, remoteLoop, clockPrescale, buildOut, txMode, rxMode,
                    txAlarmSend};

    host_bus_model host (.mclk(mclk), .interfaceSelect(interfaceSelect), .busTypeStrap(busTypeStrap),
        .addrPin(addrPin), .aleA7Pin(aleA7Pin), .readPin(readPin), .writePin(writePin),
        .chipSelectPinN(chipSelectPinN), .txModeMidPin(txModeMidPin), .adIn(adIn));

    host_port_pin_mode_decode dut (.mclk(mclk), .resetn(resetn), .interfaceSelect(interfaceSelect),
        .busTypeStrap(busTypeStrap), .addrPin(addrPin), .aleA7Pin(aleA7Pin), .readPin(readPin),
        .writePin(writePin), .chipSelectPinN(chipSelectPinN), .txModeMidPin(txModeMidPin), .adIn(adIn),
        .regAddr(regAddr), .readReq(readReq), .writeReq(writeReq), .serialSelect(serialSelect),
        .serialClkPolarity(serialClkPolarity), .serialClkPhase(serialClkPhase), .hwModeActive(hwModeActive),
        .e1Term75(e1Term75), .zeroSubstTx(zeroSubstTx), .zeroSubstRx(zeroSubstRx), .remoteLoop(remoteLoop),
        .clockPrescale(clockPrescale), .buildOut(buildOut), .txMode(txMode), .rxMode(rxMode),
        .txAlarmSend(txAlarmSend));

    // Expected {write, read} pulse from pin levels
    function automatic logic [1:0] expReq(input logic [1:0] m, input logic b, cs, rd, wr);
        logic s;
        s = (m == MODE_NONMUX && b) ? rd : !rd;
        if (cs || m[1])
            return 2'b00;
        return b ? {s & !wr, s & wr} : {!wr, !rd};
    endfunction : expReq

    // Expected hardware-mode outputs from a strap vector
    function automatic logic [17:0] expHw(input logic [21:0] s);
        logic [3:0] tx;
        logic [3:0] rx;
        tx = {s[11], s[9:8], s[19]};
        rx = {s[1], s[12], s[5], s[4]};
        return {s[14], s[21] & T1E1_MODE_MASK[tx], s[21] & T1E1_MODE_MASK[rx], s[10] & (tx == rx),
                s[13], s[20], s[18:16], tx, rx, s[15] & T1E1_MODE_MASK[tx]};
    endfunction : expHw

    // Single compare point
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    // Free-running clock
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Hang guard, far beyond the few hundred cycles needed
    initial
    begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        end_sim();
    end

    // Main sequence
    initial
    begin
        resetn = 1'b0;
        @(posedge mclk);
        #1;
        check({regAddr, readReq, writeReq, serialSelect, hwModeActive, hwOut}, 0);
        @(posedge mclk);
        resetn <= 1'b1;
        // Both bus personalities, both strobe sets, some deselected
        for (int m = 0; m < 2; m++)
            for (int b = 0; b < 2; b++)
                for (int k = 0; k < 8; k++)
                begin
                    host.setMode(m[1:0], b[0]);
                    addr = 8'($random(seed));
                    host.access(k[0], addr, k != 2 && k != 3);
                    @(posedge mclk);
                    #1;
                    check({writeReq, readReq}, expReq(interfaceSelect, busTypeStrap, chipSelectPinN, readPin, writePin));
                    if (!chipSelectPinN)
                        check(regAddr, addr);
                    @(posedge mclk);
                    #1;
                    check({writeReq, readReq}, 2'b00);
                end
        $display("test parallel done");
        host.setMode(MODE_SERIAL, 1'b0);
        repeat (8)
        begin
            host.straps(22'($random(seed)));
            @(posedge mclk);
            #1;
            check({serialSelect, readReq, writeReq}, {!chipSelectPinN, 2'b00});
            check({serialClkPolarity, serialClkPhase}, {addrPin[5], addrPin[4]});
        end
        cp = {serialClkPolarity, serialClkPhase};
        host.setMode(MODE_MUX, 1'b0);
        @(posedge mclk);
        #1;
        check({serialClkPolarity, serialClkPhase, serialSelect}, {cp, 1'b0});
        $display("test serial done");
        host.setMode(MODE_HW, 1'b0);
        for (int k = 0; k < 24; k++)
        begin
            v = 22'($random(seed));
            if (k < 6)
            begin
                // Equal tx and rx modes with loop strap high
                v[10] = 1'b1;
                v[4] = v[19];
                v[5] = v[8];
                v[12] = v[9];
                v[1] = v[11];
            end
            host.straps(v);
            @(posedge mclk);
            #1;
            check({hwModeActive, hwOut}, {1'b1, expHw(v)});
            check({readReq, writeReq, serialSelect}, 3'b000);
        end
        // Reset in mid-run, straps must come straight back
        @(posedge mclk);
        resetn <= 1'b0;
        #1;
        check({readReq, writeReq, hwModeActive, hwOut}, 0);
        @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        #1;
        check({hwModeActive, hwOut}, {1'b1, expHw(v)});
        host.setMode(MODE_MUX, 1'b0);
        @(posedge mclk);
        #1;
        check({hwModeActive, hwOut}, 0);
        $display("test hardware done");
        end_sim();
    end
endmodule : tb_top
